// ### design/tag_cmd_pkg.sv
// Shared constants, types and CRC helper for the tag command link
package tag_cmd_pkg;
  localparam logic [3:0] INS_HALT      = 4'h0;
  localparam logic [3:0] INS_SELECT    = 4'h1;
  localparam logic [3:0] INS_PAGE      = 4'h4;
  localparam logic [3:0] INS_VERIFY    = 4'h5;
  localparam logic [3:0] INS_QUAD      = 4'h6;
  localparam logic [3:0] INS_UPDATE    = 4'h7;
  localparam logic [3:0] INS_CHAL      = 4'h8;
  localparam logic [3:0] INS_WAKE_ALL  = 4'hA;
  localparam logic [3:0] INS_READ      = 4'hC;
  localparam logic [3:0] INS_SLOT_WAKE = 4'hE;
  localparam logic [3:0] INS_DETECT    = 4'hF;
  localparam int CMD_KEY_POS = 4;
  localparam int CMD_ODD_POS = 7;
  localparam logic [1:0] CODE_BAD  = 2'h3;
  localparam logic [1:0] CODE_FAST = 2'h2;
  localparam logic [15:0] CRC_POLY      = 16'h8408;
  localparam logic [15:0] CRC_PRESET_P2 = 16'hE012;
  localparam logic [15:0] CRC_PRESET_B3 = 16'hFFFF;
  localparam int CLK_MHZ         = 100;
  localparam int T_REPLY_ISO_US  = 330;
  localparam int T_REPLY_B_US    = 76;
  localparam int T_WIN_ISO_US    = 330;
  localparam int T_SLOT_ISO_US   = 160;
  localparam int T_WIN_B_US      = 119;
  localparam int T_SLOT_B_US     = 150;
  localparam int T_BURN_MIN_MS   = 4;
  localparam int T_BURN_MAX_MS   = 15;
  localparam int REPLY_ISO_CYC   = T_REPLY_ISO_US * CLK_MHZ;
  localparam int REPLY_B_CYC     = T_REPLY_B_US * CLK_MHZ;
  localparam int WIN_ISO_CYC     = (T_WIN_ISO_US + T_SLOT_ISO_US) * CLK_MHZ;
  localparam int WIN_B_CYC       = (T_WIN_B_US + T_SLOT_B_US) * CLK_MHZ;
  localparam int BURN_CYC        = T_BURN_MIN_MS * 1000 * CLK_MHZ;
  localparam int BLK_SERIAL      = 0;
  localparam int BLK_CONFIG      = 1;
  localparam int BLK_DEBIT       = 3;
  localparam int BLK_CREDIT      = 4;
  localparam int OPEN_READ_POS   = 59;
  localparam int ERASE_OK_POS    = 58;
  localparam int FRAME_MAX       = 12;
  typedef enum logic [1:0] {
    CHIP_IDLE = 2'b00, CHIP_READY = 2'b01, CHIP_SEL = 2'b10, CHIP_HALT = 2'b11
  } chip_state_type;
  typedef enum logic [2:0] {
    P_RECV = 3'b000, P_EXEC = 3'b001, P_WAIT = 3'b010, P_SEND = 3'b011, P_DROP = 3'b100
  } proc_state_type;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_SEND = 2'b01, R_WAIT = 2'b10
  } rdr_state_type;

  // One byte of the reflected CRC16, low bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ### design/tag_link_if.sv
// Byte-stream link between reader end and tag end
`timescale 1ns/1ns
`default_nettype none
interface tag_link_if;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] cmd_data;
  logic       cmd_last;
  logic       cmd_typeb;
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_data;
  logic       rsp_last;
  logic       rsp_sof_only;
  logic       rsp_fast;
  modport tag_mp (input cmd_valid, cmd_data, cmd_last, cmd_typeb, rsp_ready,
                  output cmd_ready, rsp_valid, rsp_data, rsp_last, rsp_sof_only, rsp_fast);
  modport reader_mp (output cmd_valid, cmd_data, cmd_last, cmd_typeb, rsp_ready,
                     input cmd_ready, rsp_valid, rsp_data, rsp_last, rsp_sof_only, rsp_fast);
endinterface
`default_nettype wire

// ### design/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("word_fifo depth must be a power of two of at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             push;
  logic             pop;
  assign in_ready  = (wp_r - rp_r) != (AW + 1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data  = mem_r[rp_r[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule // word_fifo
`default_nettype wire

// ### design/tag_cmd_end.sv
// Tag end: command byte decoder, access rights and reply sequencer
// Functional notes
// - Command byte: instruction, key, reply code, parity
// - Decode the eleven instruction codes
// - Key bit picks credit or debit secret
// - Anti-collision commands invalid in type B-3
// - Reply code picks reply coding and rate; only code 10 on type B frames sets rsp_fast
// - Both reply code bits set: bad command
// - Parity bit is XOR of bits 0-6
// - Wake-all wakes unhalted tag, replies bare SOF
// - Identify returns collision serial plus CRC
// - Matching select makes tag selected, returns serial
// - Halt keeps rights; only serial select revives
// - Page choose: same page clears rights, single-page silent
// - Challenge fetch feeds core; first resets it
// - Failed credit clears rights; failed debit keeps
// - Verify challenge excludes the instruction byte
// - Unreadable blocks return all ones
// - Quad fetch wraps to address zero
// - Upper three address bits ignored
// - Forbidden update silent; no-erase writes; burn time
// - Reply delay per protocol
// - Reply bytes 0 to 7, LSB first
// - CRC16 presets and coverage per protocol
// - Open read bit clear: reads of blocks 2 and up need authentication
`timescale 1ns/1ns
`default_nettype none
module tag_cmd_end import tag_cmd_pkg::*; #(
  parameter int          NUM_PAGES     = 1,
  parameter logic [63:0] COLL_SERIAL   = 64'h1357_9BDF_0246_8ACE,
  parameter int          REPLY_ISO_DLY = REPLY_ISO_CYC,
  parameter int          REPLY_B_DLY   = REPLY_B_CYC,
  parameter int          BURN_DLY      = BURN_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  tag_link_if.tag_mp      link,
  input  wire logic       b3_mode,
  output chip_state_type  chip_state,
  output logic            auth_debit,
  output logic            auth_credit,
  output logic            bad_cmd
);
  generate
    if (NUM_PAGES < 1 || NUM_PAGES > 8 || REPLY_ISO_DLY < 1 || REPLY_B_DLY < 1 || BURN_DLY < 1) begin : g_bad
      $error("tag_cmd_end parameters out of range");
    end
  endgenerate
  logic [63:0]    mem_r [32];
  logic [7:0]     rx_r [FRAME_MAX];
  logic [3:0]     rx_cnt_r;
  logic [15:0]    rx_crc_r;
  logic           typeb_r;
  proc_state_type proc_r;
  chip_state_type chip_r;
  logic           deb_r, cred_r, first_r, key_r, sof_r, fast_r, crc_en_r;
  logic [2:0]     page_r;
  logic [63:0]    acc_r;
  logic [63:0]    blk_r [4];
  logic [5:0]     len_r, idx_r;
  logic [15:0]    tx_crc_r;
  logic [7:0]     out_r;
  logic [31:0]    tmr_r;
  logic [9:0]     f_out;
  logic           f_valid, f_ready;
  word_fifo #(.WIDTH(10), .DEPTH(4)) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (link.cmd_valid),
    .in_ready  (link.cmd_ready),
    .in_data   ({link.cmd_typeb, link.cmd_last, link.cmd_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_out)
  );
  assign f_ready = (proc_r == P_RECV) || (proc_r == P_DROP);

  // Frame decode
  logic [7:0]  cmd;
  logic [3:0]  ins;
  logic [4:0]  blk;
  logic [63:0] rx_word;
  logic        odd_ok, reserved, anticol, frame_ok, sel_ok;
  assign cmd      = rx_r[0];
  assign ins      = cmd[3:0];
  assign blk      = rx_r[1][4:0];
  assign rx_word  = {rx_r[8], rx_r[7], rx_r[6], rx_r[5], rx_r[4], rx_r[3], rx_r[2], rx_r[1]};
  assign odd_ok   = cmd[CMD_ODD_POS] == ^cmd[6:0];
  assign reserved = ins == 4'h2 || ins == 4'h3 || ins == 4'h9 || ins == 4'hB || ins == 4'hD;
  assign anticol  = ins == INS_WAKE_ALL || ins == INS_SLOT_WAKE || ins == INS_SELECT
                 || ins == INS_DETECT || ins == INS_HALT;
  assign frame_ok = odd_ok && !reserved && cmd[6:5] != CODE_BAD
                 && (rx_cnt_r < 4'd2 || rx_crc_r == 16'h0000) && !(b3_mode && anticol);
  assign sel_ok   = chip_r == CHIP_SEL || b3_mode;

  function automatic logic area_ok(input logic [4:0] b);
    return ({3'b000, b} <= mem_r[BLK_CONFIG][7:0]) ? deb_r : cred_r;
  endfunction
  function automatic logic [63:0] rd_word(input logic [4:0] b);
    if (b < 5'd2 || mem_r[BLK_CONFIG][OPEN_READ_POS] || area_ok(b)) begin
      return mem_r[b];
    end
    return 64'hFFFF_FFFF_FFFF_FFFF;
  endfunction

  // Command execution, evaluated in P_EXEC
  logic           ex_reply, ex_sof, ex_crc, ex_wr, deb_nxt, cred_nxt, first_nxt, key_nxt;
  logic [5:0]     ex_len;
  logic [63:0]    ex_blk [4];
  logic [63:0]    acc_nxt, new_word, key_word, upd_word;
  logic [2:0]     page_nxt;
  chip_state_type chip_nxt;
  assign upd_word = {rx_r[9], rx_r[8], rx_r[7], rx_r[6], rx_r[5], rx_r[4], rx_r[3], rx_r[2]};
  assign new_word = mem_r[BLK_CONFIG][ERASE_OK_POS] ? upd_word : (mem_r[blk] & upd_word);
  assign key_word = key_r ? mem_r[BLK_CREDIT] : mem_r[BLK_DEBIT];
  always_comb begin
    ex_reply  = 1'b0;
    ex_sof    = 1'b0;
    ex_crc    = 1'b1;
    ex_wr     = 1'b0;
    ex_len    = 6'd8;
    chip_nxt  = chip_r;
    deb_nxt   = deb_r;
    cred_nxt  = cred_r;
    first_nxt = first_r;
    key_nxt   = key_r;
    acc_nxt   = acc_r;
    page_nxt  = page_r;
    for (int i = 0; i < 4; i++) begin
      ex_blk[i] = rd_word(blk + 5'(i));
    end
    if (frame_ok) begin
      case (ins)
        INS_WAKE_ALL: if (chip_r != CHIP_HALT) begin
          chip_nxt = CHIP_READY;
          ex_reply = 1'b1;
          ex_sof   = 1'b1;
        end
        INS_SLOT_WAKE: if (chip_r == CHIP_READY) begin
          ex_reply = 1'b1;
          ex_sof   = 1'b1;
        end
        INS_DETECT: if (chip_r == CHIP_READY || chip_r == CHIP_SEL) begin
          ex_reply  = 1'b1;
          ex_blk[0] = mem_r[BLK_SERIAL];
        end
        INS_SELECT: if ((chip_r == CHIP_READY && rx_word == COLL_SERIAL)
                     || (chip_r == CHIP_HALT && rx_word == mem_r[BLK_SERIAL])) begin
          chip_nxt  = CHIP_SEL;
          ex_reply  = 1'b1;
          ex_blk[0] = mem_r[BLK_SERIAL];
        end
        INS_HALT: if (chip_r == CHIP_SEL) begin
          chip_nxt = CHIP_HALT;
        end
        INS_READ: if (sel_ok) begin
          ex_reply = 1'b1;
        end else if (chip_r == CHIP_READY) begin
          ex_reply  = 1'b1;
          ex_blk[0] = COLL_SERIAL;
        end
        INS_QUAD: if (sel_ok) begin
          ex_reply = 1'b1;
          ex_len   = 6'd32;
        end
        INS_PAGE: if (sel_ok && NUM_PAGES > 1) begin
          if (rx_r[1][2:0] == page_r) begin
            deb_nxt  = 1'b0;
            cred_nxt = 1'b0;
          end
          page_nxt  = rx_r[1][2:0];
          ex_reply  = 1'b1;
          ex_blk[0] = mem_r[BLK_CONFIG];
        end
        INS_CHAL: if (sel_ok) begin
          acc_nxt   = first_r ? ex_blk[0] : {acc_r[62:0], acc_r[63]} ^ ex_blk[0];
          first_nxt = 1'b0;
          key_nxt   = cmd[CMD_KEY_POS];
          ex_reply  = 1'b1;
        end
        INS_VERIFY: if (sel_ok) begin
          first_nxt = 1'b1;
          if (rx_word[63:32] == (acc_r[31:0] ^ key_word[31:0] ^ rx_word[31:0])) begin
            deb_nxt  = deb_r | !key_r;
            cred_nxt = cred_r | key_r;
          end else if (key_r) begin
            deb_nxt  = 1'b0;
            cred_nxt = 1'b0;
          end
          ex_reply  = 1'b1;
          ex_crc    = 1'b0;
          ex_len    = 6'd4;
          ex_blk[0] = acc_r ^ key_word;
        end
        INS_UPDATE: if (sel_ok && blk >= 5'd2 && area_ok(blk)) begin
          ex_wr     = 1'b1;
          ex_reply  = 1'b1;
          ex_blk[0] = new_word;
        end
        default: ex_reply = 1'b0;
      endcase
    end
    if (ex_sof) begin
      ex_len = 6'd0;
      ex_crc = 1'b0;
    end
  end

  // Frame reception and reply sequencing
  logic [5:0] total;
  logic [7:0] nxt_byte;
  logic [5:0] nidx;
  logic [15:0] crc_upd;
  assign total   = len_r + (crc_en_r ? 6'd2 : 6'd0);
  assign nidx    = idx_r + 6'd1;
  assign crc_upd = (idx_r < len_r) ? crc_byte(tx_crc_r, out_r) : tx_crc_r;
  assign nxt_byte = (nidx < len_r) ? blk_r[nidx[4:3]][{nidx[2:0], 3'b000} +: 8]
                  : (nidx == len_r) ? crc_upd[7:0] : crc_upd[15:8];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      proc_r   <= P_RECV;
      rx_cnt_r <= '0;
      rx_crc_r <= b3_mode ? CRC_PRESET_B3 : CRC_PRESET_P2;
      typeb_r  <= 1'b0;
      tmr_r    <= '0;
      idx_r    <= '0;
      out_r    <= '0;
      tx_crc_r <= CRC_PRESET_P2;
      bad_cmd  <= 1'b0;
    end else begin
      bad_cmd <= (proc_r == P_EXEC) && odd_ok && cmd[6:5] == CODE_BAD;
      case (proc_r)
        P_RECV, P_DROP: if (f_valid) begin
          if (rx_cnt_r < 4'(FRAME_MAX)) begin
            rx_r[rx_cnt_r] <= f_out[7:0];
            rx_cnt_r       <= rx_cnt_r + 4'd1;
          end
          if (rx_cnt_r != 4'd0 || b3_mode) begin
            rx_crc_r <= crc_byte(rx_crc_r, f_out[7:0]);
          end
          typeb_r <= f_out[9];
          if (f_out[8]) begin
            proc_r <= (proc_r == P_DROP) ? P_RECV : P_EXEC;
          end
        end
        P_EXEC: begin
          rx_cnt_r <= '0;
          rx_crc_r <= b3_mode ? CRC_PRESET_B3 : CRC_PRESET_P2;
          tmr_r    <= ex_wr ? 32'(BURN_DLY) : typeb_r ? 32'(REPLY_B_DLY) : 32'(REPLY_ISO_DLY);
          proc_r   <= ex_reply ? P_WAIT : P_RECV;
        end
        P_WAIT: begin
          tmr_r <= tmr_r - 32'd1;
          if (tmr_r == 32'd1) begin
            proc_r   <= P_SEND;
            idx_r    <= '0;
            out_r    <= blk_r[0][7:0];
            tx_crc_r <= b3_mode ? CRC_PRESET_B3 : CRC_PRESET_P2;
          end
        end
        P_SEND: if (link.rsp_ready) begin
          if (sof_r || nidx >= total) begin
            proc_r <= P_RECV;
          end
          idx_r    <= nidx;
          tx_crc_r <= crc_upd;
          out_r    <= nxt_byte;
        end
        default: proc_r <= P_RECV;
      endcase
    end
  end

  // Chip state, rights and reply set-up
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chip_r   <= CHIP_IDLE;
      deb_r    <= 1'b0;
      cred_r   <= 1'b0;
      first_r  <= 1'b1;
      key_r    <= 1'b0;
      acc_r    <= '0;
      page_r   <= '0;
      len_r    <= '0;
      sof_r    <= 1'b0;
      crc_en_r <= 1'b0;
      fast_r   <= 1'b0;
    end else if (proc_r == P_EXEC) begin
      chip_r   <= chip_nxt;
      deb_r    <= deb_nxt;
      cred_r   <= cred_nxt;
      first_r  <= first_nxt;
      key_r    <= key_nxt;
      acc_r    <= acc_nxt;
      page_r   <= page_nxt;
      len_r    <= ex_len;
      sof_r    <= ex_sof;
      crc_en_r <= ex_crc;
      fast_r   <= typeb_r && cmd[6:5] == CODE_FAST;
      for (int i = 0; i < 4; i++) begin
        blk_r[i] <= ex_blk[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (proc_r == P_EXEC && ex_wr) begin
      mem_r[blk] <= new_word;
    end
  end

  assign link.rsp_valid    = proc_r == P_SEND;
  assign link.rsp_data     = out_r;
  assign link.rsp_last     = sof_r || nidx >= total;
  assign link.rsp_sof_only = sof_r;
  assign link.rsp_fast     = fast_r;
  assign chip_state        = chip_r;
  assign auth_debit        = deb_r;
  assign auth_credit       = cred_r;
endmodule // tag_cmd_end
`default_nettype wire

// ### design/reader_cmd_end.sv
// Reader end: builds command frames and collects tag replies
`timescale 1ns/1ns
`default_nettype none
module reader_cmd_end import tag_cmd_pkg::*; #(
  parameter int WAIT_CYC = WIN_ISO_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  tag_link_if.reader_mp    link,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [3:0]  req_instr,
  input  wire logic        req_key,
  input  wire logic [1:0]  req_code,
  input  wire logic        req_typeb,
  input  wire logic        req_b3,
  input  wire logic [3:0]  req_len,
  input  wire logic [71:0] req_payload,
  output logic             rx_valid,
  output logic [7:0]       rx_byte,
  output logic             rx_end,
  output logic             rx_sof,
  output logic             rx_crc_ok,
  output logic             rx_timeout
);
  generate
    if (WAIT_CYC < 1) begin : g_bad
      $error("reader_cmd_end wait count must be positive");
    end
  endgenerate
  rdr_state_type st_r;
  logic [7:0]    byte_r [12];
  logic [3:0]    idx_r, last_r;
  logic [15:0]   crc_r;
  logic          b3_r, typeb_r;
  logic [31:0]   tmr_r;
  logic [6:0]    low7;
  logic [15:0]   crc_p;
  logic [15:0]   pre;
  assign low7  = {req_code, req_key && req_instr == INS_CHAL, req_instr};
  assign pre   = req_b3 ? CRC_PRESET_B3 : CRC_PRESET_P2;
  assign req_ready = st_r == R_IDLE;

  // Preset CRC over the payload, with the command byte only for type B-3
  always_comb begin
    crc_p = req_b3 ? crc_byte(pre, {^low7, low7}) : pre;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < req_len) begin
        crc_p = crc_byte(crc_p, req_payload[8*i +: 8]);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r       <= R_IDLE;
      idx_r      <= '0;
      last_r     <= '0;
      crc_r      <= CRC_PRESET_P2;
      b3_r       <= 1'b0;
      typeb_r    <= 1'b0;
      tmr_r      <= '0;
      rx_valid   <= 1'b0;
      rx_byte    <= '0;
      rx_end     <= 1'b0;
      rx_sof     <= 1'b0;
      rx_crc_ok  <= 1'b0;
      rx_timeout <= 1'b0;
    end else begin
      rx_valid   <= 1'b0;
      rx_end     <= 1'b0;
      rx_timeout <= 1'b0;
      case (st_r)
        R_IDLE: if (req_valid) begin
          byte_r[0] <= {^low7, low7};
          for (int i = 0; i < 9; i++) begin
            byte_r[i+1] <= req_payload[8*i +: 8];
          end
          byte_r[req_len + 4'd1] <= crc_p[7:0];
          byte_r[req_len + 4'd2] <= crc_p[15:8];
          last_r  <= (req_len == 4'd0) ? 4'd0 : req_len + 4'd2;
          idx_r   <= '0;
          b3_r    <= req_b3;
          typeb_r <= req_typeb;
          st_r    <= R_SEND;
        end
        R_SEND: if (link.cmd_ready) begin
          idx_r <= idx_r + 4'd1;
          if (idx_r == last_r) begin
            st_r  <= R_WAIT;
            tmr_r <= 32'(WAIT_CYC);
            crc_r <= b3_r ? CRC_PRESET_B3 : CRC_PRESET_P2;
          end
        end
        R_WAIT: begin
          tmr_r <= tmr_r - 32'd1;
          if (link.rsp_valid) begin
            rx_valid <= !link.rsp_sof_only;
            rx_byte  <= link.rsp_data;
            crc_r    <= crc_byte(crc_r, link.rsp_data);
            if (link.rsp_last) begin
              rx_end    <= 1'b1;
              rx_sof    <= link.rsp_sof_only;
              rx_crc_ok <= crc_byte(crc_r, link.rsp_data) == 16'h0000;
              st_r      <= R_IDLE;
            end
          end else if (tmr_r == 32'd1) begin
            rx_timeout <= 1'b1;
            st_r       <= R_IDLE;
          end
        end
        default: st_r <= R_IDLE;
      endcase
    end
  end

  assign link.cmd_valid = st_r == R_SEND;
  assign link.cmd_data  = byte_r[idx_r];
  assign link.cmd_last  = idx_r == last_r;
  assign link.cmd_typeb = typeb_r;
  assign link.rsp_ready = st_r == R_WAIT;
endmodule // reader_cmd_end
`default_nettype wire

// ### sim/tag_link_checker.sv
// Protocol checker for the tag command link
`timescale 1ns/1ns
`default_nettype none
module tag_link_checker import tag_cmd_pkg::*; (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_last,
  input wire logic       cmd_typeb,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last,
  input wire logic       rsp_sof_only,
  input wire logic       rsp_fast
);
  logic       take;
  logic       bad_now;
  logic       first_r;
  logic       bad_r;
  logic       typeb_r;
  logic [1:0] code_r;
  assign take    = cmd_valid && cmd_ready;
  assign bad_now = first_r ? ((^cmd_data) || cmd_data[6:5] == CODE_BAD) : bad_r;
  always_ff @(posedge clk_sys) begin
    if (rst) first_r <= 1'b1;
    else if (take) first_r <= cmd_last;
  end
  always_ff @(posedge clk_sys) begin
    if (take && first_r) begin
      bad_r   <= bad_now;
      typeb_r <= cmd_typeb;
      code_r  <= cmd_data[6:5];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_frame_end;
    take && cmd_last;
  endsequence
  a_cmd_held: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("command byte changed before taken");
  a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("reply byte changed before taken");
  a_sof_single: assert property (rsp_valid && rsp_sof_only |-> rsp_last)
    else $error("bare start of frame not a single beat");
  a_fast_code: assert property (rsp_valid && rsp_fast |-> typeb_r && code_r == CODE_FAST)
    else $error("fast reply without type B code 10");
  a_bad_silent: assert property (s_frame_end ##0 bad_now |=> !rsp_valid [*8])
    else $error("reply to a refused command byte");
  a_reply_delay: assert property (s_frame_end |=> !rsp_valid [*5])
    else $error("reply before the reply delay");
  a_last_drop: assert property (rsp_valid && rsp_ready && rsp_last |=> !rsp_valid)
    else $error("reply continues after last byte");
  a_reset_quiet: assert property ($fell(rst) |-> !rsp_valid && cmd_ready)
    else $error("link not idle after reset");
endmodule // tag_link_checker
`default_nettype wire

// ### sim/test_contactless_tag_command_decoder.sv
// Self-checking bench: reader end and tag end joined over the link
`timescale 1ns/1ns
`default_nettype none
module test_contactless_tag_command_decoder import tag_cmd_pkg::*; ();
  localparam logic [63:0] SERIAL = 64'h0F1E_2D3C_4B5A_6978;
  localparam logic [3:0]  RSV[5] = '{4'h2, 4'h3, 4'h9, 4'hB, 4'hD};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_key = 1'b0, req_typeb = 1'b0, req_b3 = 1'b0;
  logic [3:0] req_instr = 4'h0, req_len = 4'h0;
  logic [1:0] req_code = 2'h0;
  logic [71:0] req_payload = '0;
  logic req_ready, rx_valid, rx_end, rx_sof, rx_crc_ok, rx_timeout;
  logic auth_debit, auth_credit, bad_cmd, got_sof, got_to, got_crc;
  logic b3_mode = 1'b0;
  logic [7:0] rx_byte;
  logic [7:0] q[$];
  chip_state_type chip_state;
  int error_cnt = 0, checked = 0, bad_cnt = 0;
  tag_link_if tag_link_if_i ();
  tag_cmd_end #(.COLL_SERIAL(SERIAL), .REPLY_ISO_DLY(5), .REPLY_B_DLY(5), .BURN_DLY(20)) tag_cmd_end_i (
    .clk_sys, .rst, .link(tag_link_if_i), .b3_mode, .chip_state, .auth_debit, .auth_credit, .bad_cmd);
  reader_cmd_end #(.WAIT_CYC(200)) reader_cmd_end_i (.clk_sys, .rst, .link(tag_link_if_i), .req_valid,
    .req_ready, .req_instr, .req_key, .req_code, .req_typeb, .req_b3, .req_len, .req_payload, .rx_valid,
    .rx_byte, .rx_end, .rx_sof, .rx_crc_ok, .rx_timeout);
  tag_link_checker tag_link_checker_i (.clk_sys, .rst, .cmd_valid(tag_link_if_i.cmd_valid),
    .cmd_ready(tag_link_if_i.cmd_ready), .cmd_data(tag_link_if_i.cmd_data), .cmd_last(tag_link_if_i.cmd_last),
    .cmd_typeb(tag_link_if_i.cmd_typeb), .rsp_valid(tag_link_if_i.rsp_valid),
    .rsp_ready(tag_link_if_i.rsp_ready), .rsp_data(tag_link_if_i.rsp_data), .rsp_last(tag_link_if_i.rsp_last),
    .rsp_sof_only(tag_link_if_i.rsp_sof_only), .rsp_fast(tag_link_if_i.rsp_fast));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (bad_cmd === 1'b1) bad_cnt <= bad_cnt + 1;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected reply CRC over one word, bit by bit, low bit first
  function automatic logic [15:0] exp_crc(input logic [63:0] w);
    logic [15:0] c;
    c = CRC_PRESET_P2;
    for (int i = 0; i < 64; i++) begin
      c = (c[0] ^ w[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One frame out, then collect the reply or the timeout
  task automatic frame(input logic [3:0] ins, input logic [1:0] code, input logic tb, input logic [3:0] len,
                       input logic [71:0] pl);
    int n;
    n = 0;
    q.delete();
    {req_instr, req_code, req_typeb, req_len, req_payload} = {ins, code, tb, len, pl};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    while (n < 500 && rx_end !== 1'b1 && rx_timeout !== 1'b1) begin
      @(posedge clk_sys);
      #1 n++;
      if (rx_valid === 1'b1) q.push_back(rx_byte);
    end
    got_to = rx_timeout;
    @(posedge clk_sys);
    #1 {got_sof, got_crc} = {rx_sof, rx_crc_ok};
    if (n >= 500) begin
      chk(1'b0, 1'b1);
      wrap_up();
    end
  endtask
  initial begin
    void'($urandom(10));
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'b0;
    foreach (RSV[i]) begin
      frame(RSV[i], 2'h0, 1'b0, 4'h0, '0);
      chk(got_to, 1'b1);
    end
    frame(INS_WAKE_ALL, CODE_BAD, 1'b0, 4'h0, '0);
    chk(got_to, 1'b1);
    chk(bad_cnt > 0, 1'b1);
    chk(chip_state, CHIP_IDLE);
    $display("refusal test done");
    repeat (6) begin
      frame(INS_WAKE_ALL, {1'($urandom), 1'b0}, 1'($urandom), 4'h0, '0);
      chk(got_sof, 1'b1);
    end
    chk(chip_state, CHIP_READY);
    b3_mode = 1'b1;
    frame(INS_WAKE_ALL, 2'h0, 1'b0, 4'h0, '0);
    chk(got_to, 1'b1);
    chk(chip_state, CHIP_READY);
    b3_mode = 1'b0;
    $display("wake test done");
    frame(INS_READ, 2'h0, 1'b0, 4'h0, '0);
    for (int i = 0; i < 8; i++) chk(q[i], SERIAL[8*i+:8]);
    chk(got_crc, 1'b1);
    chk({q[9], q[8]}, exp_crc(SERIAL));
    frame(INS_SELECT, 2'h0, 1'b0, 4'h8, {8'h00, SERIAL ^ 64'h0000_0000_0000_0001});
    chk(chip_state, CHIP_READY);
    frame(INS_SELECT, 2'h0, 1'b0, 4'h8, {8'h00, SERIAL});
    chk(got_to, 1'b0);
    chk(chip_state, CHIP_SEL);
    frame(INS_PAGE, 2'h0, 1'b0, 4'h1, 72'h01);
    chk(got_to, 1'b1);
    $display("identify and select test done");
    frame(INS_HALT, 2'h0, 1'b0, 4'h0, '0);
    chk(chip_state, CHIP_HALT);
    chk({auth_debit, auth_credit}, 2'b00);
    frame(INS_WAKE_ALL, 2'h0, 1'b0, 4'h0, '0);
    chk(got_to, 1'b1);
    frame(INS_SLOT_WAKE, 2'h0, 1'b0, 4'h0, '0);
    chk(got_to, 1'b1);
    chk(chip_state, CHIP_HALT);
    $display("halt test done");
    wrap_up();
  end
endmodule // test_contactless_tag_command_decoder
`default_nettype wire
